// >>> design/hbsc_top.v
`timescale 1ns/1ns
`default_nettype none
`include "hbsc_defs.vh"

module hbsc_top #(
	parameter [`HBSC_SC_CNT_W-1:0] SC_LONG_CYC  = `HBSC_SC_LONG_CYC,
	parameter [`HBSC_SC_CNT_W-1:0] SC_SHORT_CYC = `HBSC_SC_SHORT_CYC
) (
	input  wire                      CLK,
	input  wire                      RSTN,
	input  wire                      CS_N,
	input  wire                      SERIAL_CLK,
	input  wire                      SERIAL_INPUT,
	output reg                       SERIAL_OUT,
	output reg                       SERIAL_OUT_OE,
	input  wire                      STANDBY_PIN_N,
	input  wire                      THERMAL_PREWARN,
	input  wire                      OVERTEMP,
	input  wire                      LOAD_SUPPLY_LOW,
	input  wire [`HBSC_NUM_SW-1:0]   SHORT_CIRCUIT,
	input  wire [`HBSC_NUM_SW-1:0]   OPEN_LOAD,
	output reg  [`HBSC_NUM_SW-1:0]   SWITCH_ON,
	output reg                       OPEN_LOAD_CHECK_EN
);

	localparam [1:0] ST_IDLE  = 2'h1;
	localparam [1:0] ST_FRAME = 2'h2;

	// Every input but CLK and RSTN is asynchronous to CLK, so all of them go through one bundle.
	wire [`HBSC_SYNC_W-1:0] raw_in;
	wire [`HBSC_SYNC_W-1:0] syn;

	assign raw_in = {CS_N, SERIAL_CLK, SERIAL_INPUT, STANDBY_PIN_N, THERMAL_PREWARN,
		OVERTEMP, LOAD_SUPPLY_LOW, SHORT_CIRCUIT, OPEN_LOAD};

	hbsc_sync #(
		.W       (`HBSC_SYNC_W),
		.RST_VAL (`HBSC_SYNC_RST)
	) u_sync (
		.clk      (CLK),
		.rst_n    (RSTN),
		.async_in (raw_in),
		.sync_out (syn)
	);

	wire                     cs_n_s;
	wire                     sclk_s;
	wire                     sdi_s;
	wire                     stby_pin_n_s;
	wire                     tp_s;
	wire                     ot_s;
	wire                     uv_s;
	wire [`HBSC_NUM_SW-1:0]  short_s;
	wire [`HBSC_NUM_SW-1:0]  open_s;

	assign cs_n_s       = syn[`HBSC_Y_CS_N];
	assign sclk_s       = syn[`HBSC_Y_SCLK];
	assign sdi_s        = syn[`HBSC_Y_SDI];
	assign stby_pin_n_s = syn[`HBSC_Y_STBY_N];
	assign tp_s         = syn[`HBSC_Y_TP];
	assign ot_s         = syn[`HBSC_Y_OT];
	assign uv_s         = syn[`HBSC_Y_UV];
	assign short_s      = syn[`HBSC_Y_SC_HI:`HBSC_Y_SC_LO];
	assign open_s       = syn[`HBSC_Y_OL_HI:`HBSC_Y_OL_LO];

	// Edge detection on the synchronised chip select and serial clock.
	reg cs_n_dly_q;
	reg sclk_dly_q;

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			cs_n_dly_q <= 1'b1;
			sclk_dly_q <= 1'b0;
		end else begin
			cs_n_dly_q <= cs_n_s;
			sclk_dly_q <= sclk_s;
		end
	end

	wire cs_fall;
	wire cs_rise;
	wire sclk_fall;
	wire sclk_rise;

	assign cs_fall   = cs_n_dly_q & ~cs_n_s;
	assign cs_rise   = ~cs_n_dly_q & cs_n_s;
	assign sclk_fall = sclk_dly_q & ~sclk_s;
	assign sclk_rise = ~sclk_dly_q & sclk_s;

	// Serial frame engine.
	reg [1:0]                state_q;
	reg [`HBSC_WORD_W-1:0]   rx_q;
	reg [`HBSC_WORD_W-1:0]   tx_q;
	reg [`HBSC_CNT_W-1:0]    cnt_q;
	reg                      first_rise_q;
	wire [`HBSC_WORD_W-1:0]  status_word;
	wire                     apply;

	// A short frame is an abort: neither register moves.
	assign apply = (state_q == ST_FRAME) & cs_rise & (cnt_q == `HBSC_FRAME_BITS);

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q       <= ST_IDLE;
			rx_q          <= `HBSC_CTRL_RST;
			tx_q          <= `HBSC_STATUS_ALL;
			cnt_q         <= `HBSC_CNT_ZERO;
			first_rise_q  <= 1'b0;
			SERIAL_OUT    <= 1'b0;
			SERIAL_OUT_OE <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				SERIAL_OUT_OE <= 1'b0;
				if (cs_fall) begin
					state_q       <= ST_FRAME;
					tx_q          <= status_word;
					SERIAL_OUT    <= status_word[`HBSC_S_TP];
					SERIAL_OUT_OE <= 1'b1;
					cnt_q         <= `HBSC_CNT_ZERO;
					first_rise_q  <= 1'b1;
				end
			end
			ST_FRAME: begin
				if (cs_rise) begin
					state_q       <= ST_IDLE;
					SERIAL_OUT    <= 1'b0;
					SERIAL_OUT_OE <= 1'b0;
				end else if (sclk_fall) begin
					// Bit 0 arrives first and ends up at the bottom after 16 shifts.
					rx_q <= {sdi_s, rx_q[`HBSC_WORD_W-1:1]};
					if (cnt_q != `HBSC_FRAME_BITS) begin
						cnt_q <= cnt_q + `HBSC_CNT_ONE;
					end
				end else if (sclk_rise) begin
					// Bit 0 is already on the line, so the first rising edge only arms the shift.
					if (first_rise_q) begin
						first_rise_q <= 1'b0;
					end else begin
						tx_q       <= {1'b0, tx_q[`HBSC_WORD_W-1:1]};
						SERIAL_OUT <= tx_q[1];
					end
				end
			end
			default: begin
				state_q       <= ST_IDLE;
				SERIAL_OUT    <= 1'b0;
				SERIAL_OUT_OE <= 1'b0;
			end
			endcase
		end
	end

	// Control word, applied only as a whole at the end of a full frame.
	reg [`HBSC_WORD_W-1:0] ctrl_q;
	wire                   status_reset_request;

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_q <= `HBSC_CTRL_RST;
		end else if (apply) begin
			ctrl_q <= rx_q;
		end
	end

	assign status_reset_request = apply & rx_q[`HBSC_C_SRR];

	wire standby;
	wire ol_active;
	wire long_delay;

	assign standby    = ~ctrl_q[`HBSC_C_SI] | ~stby_pin_n_s;
	assign ol_active  = ~ctrl_q[`HBSC_C_OLD];
	assign long_delay = ctrl_q[`HBSC_C_SCT];

	// Sticky fault flags; undervoltage or overtemperature present in the clearing cycle keeps its flag set, a short only if it trips in that cycle.
	reg supply_fail_q;
	reg ot_latch_q;
	reg short_detected_q;

	wire [`HBSC_NUM_SW-1:0] trip;
	wire [`HBSC_NUM_SW-1:0] short_off;

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			supply_fail_q    <= 1'b0;
			ot_latch_q       <= 1'b0;
			short_detected_q <= 1'b0;
		end else begin
			supply_fail_q    <= uv_s | (supply_fail_q & ~status_reset_request);
			ot_latch_q       <= ot_s | (ot_latch_q & ~status_reset_request);
			short_detected_q <= (|trip) | (short_detected_q & ~status_reset_request);
		end
	end

	// Per-switch short-circuit timer and shutdown latch.
	wire [`HBSC_SC_CNT_W-1:0] sc_limit;

	assign sc_limit = long_delay ? SC_LONG_CYC : SC_SHORT_CYC;

	genvar gi;
	generate
		for (gi = 0; gi < `HBSC_NUM_SW; gi = gi + 1) begin : g_sw
			reg  [`HBSC_SC_CNT_W-1:0] sc_cnt_q;
			reg                       off_q;
			wire                      shorted;

			// Each channel owns its latch, so the shared vector has one driver per bit.
			assign short_off[gi] = off_q;

			// The timer only runs while the stage is really driving into the short.
			assign shorted  = short_s[gi] & SWITCH_ON[gi];
			assign trip[gi] = shorted & (sc_cnt_q + `HBSC_SC_CNT_ONE >= sc_limit);

			always @(posedge CLK or negedge RSTN) begin
				if (!RSTN) begin
					sc_cnt_q <= `HBSC_SC_CNT_ZERO;
					off_q    <= 1'b0;
				end else begin
					if (!shorted || trip[gi]) begin
						sc_cnt_q <= `HBSC_SC_CNT_ZERO;
					end else begin
						sc_cnt_q <= sc_cnt_q + `HBSC_SC_CNT_ONE;
					end
					off_q <= trip[gi] | (off_q & ~status_reset_request);
				end
			end
		end
	endgenerate

	// Stage drive: undervoltage and standby disable only while present; overtemperature and short circuit latch.
	wire [`HBSC_NUM_SW-1:0] sw_on_d;
	wire                    global_off;

	assign global_off = standby | ot_latch_q | uv_s;
	assign sw_on_d    = ctrl_q[`HBSC_C_SW_HI:`HBSC_C_SW_LO] & ~short_off & {`HBSC_NUM_SW{~global_off}};

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			SWITCH_ON          <= {`HBSC_NUM_SW{1'b0}};
			OPEN_LOAD_CHECK_EN <= 1'b0;
		end else begin
			SWITCH_ON          <= sw_on_d;
			OPEN_LOAD_CHECK_EN <= ol_active;
		end
	end

	// Status word assembly.
	wire [`HBSC_NUM_SW-1:0] sw_status;

	// An on stage cannot be judged for open load, so it reads as no open load.
	assign sw_status = ol_active ? (open_s & ~ctrl_q[`HBSC_C_SW_HI:`HBSC_C_SW_LO]) : SWITCH_ON;

	assign status_word = ot_latch_q ? `HBSC_STATUS_ALL :
		{supply_fail_q, standby, short_detected_q, sw_status, tp_s};

endmodule

`default_nettype wire

// >>> design/hbsc_defs.vh
`ifndef HBSC_DEFS_VH
`define HBSC_DEFS_VH

// Frame and word geometry.
`define HBSC_WORD_W         16
`define HBSC_CNT_W          5
`define HBSC_FRAME_BITS     5'h10
`define HBSC_CNT_ZERO       5'h00
`define HBSC_CNT_ONE        5'h01
`define HBSC_NUM_SW         12

// Control word fields and reset value.
`define HBSC_CTRL_RST       16'he000
`define HBSC_C_SRR          0
`define HBSC_C_SW_LO        1
`define HBSC_C_SW_HI        12
`define HBSC_C_OLD          13
`define HBSC_C_SCT          14
`define HBSC_C_SI           15

// Status word fields.
`define HBSC_S_TP           0
`define HBSC_S_SW_LO        1
`define HBSC_S_SCD          13
`define HBSC_S_STBY         14
`define HBSC_S_PSF          15
`define HBSC_STATUS_ALL     16'hffff

// Synchroniser bundle layout.
`define HBSC_SYNC_W         31
`define HBSC_SYNC_RST       31'h40000000
`define HBSC_Y_CS_N         30
`define HBSC_Y_SCLK         29
`define HBSC_Y_SDI          28
`define HBSC_Y_STBY_N       27
`define HBSC_Y_TP           26
`define HBSC_Y_OT           25
`define HBSC_Y_UV           24
`define HBSC_Y_SC_HI        23
`define HBSC_Y_SC_LO        12
`define HBSC_Y_OL_HI        11
`define HBSC_Y_OL_LO        0

// Short-circuit shutdown delays in 50 ns clock cycles: 12 ms long, 1.5 ms short.
`define HBSC_SC_LONG_CYC    18'h3a980
`define HBSC_SC_SHORT_CYC   18'h07530
`define HBSC_SC_CNT_W       18
`define HBSC_SC_CNT_ZERO    18'h00000
`define HBSC_SC_CNT_ONE     18'h00001

`endif

// >>> design/hbsc_sync.v
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for a bundle of asynchronous levels.
module hbsc_sync #(
	parameter             W       = 1,
	parameter [W-1:0]     RST_VAL = {W{1'b0}}
) (
	input  wire           clk,
	input  wire           rst_n,
	input  wire [W-1:0]   async_in,
	output wire [W-1:0]   sync_out
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule

`default_nettype wire

// >>> dv/hbsc_host.sv
`timescale 1ns/1ns
`default_nettype none
module hbsc_host (
	input  wire logic clk,
	input  wire logic sdo,
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic sdi
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi  = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// A frame shorter than 16 bits aborts; only its first bits are read back.
	task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
		rx = 'x;
		@(posedge clk);
		cs_n <= 1'b0;
		tick(8);
		for (int i = 0; i < n; i++) begin
			sdi  <= tx[i];
			sclk <= 1'b1;
			tick(5);
			rx[i] = sdo;
			sclk <= 1'b0;
			tick(3);
		end
		// The host drives the data pin low after the last bit.
		sdi <= 1'b0;
		tick(2);
		cs_n <= 1'b1;
		tick(8);
	endtask
endmodule
`default_nettype wire

// >>> dv/hbsc_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "hbsc_defs.vh"
module hbsc_top_asserts #(
	parameter [`HBSC_SC_CNT_W-1:0] SC_LONG_CYC  = `HBSC_SC_LONG_CYC,
	parameter [`HBSC_SC_CNT_W-1:0] SC_SHORT_CYC = `HBSC_SC_SHORT_CYC
) (
	input wire logic                    CLK,
	input wire logic                    RSTN,
	input wire logic                    CS_N,
	input wire logic                    SERIAL_CLK,
	input wire logic                    SERIAL_OUT,
	input wire logic                    SERIAL_OUT_OE,
	input wire logic                    STANDBY_PIN_N,
	input wire logic                    OVERTEMP,
	input wire logic                    LOAD_SUPPLY_LOW,
	input wire logic [`HBSC_NUM_SW-1:0] SHORT_CIRCUIT,
	input wire logic [`HBSC_NUM_SW-1:0] SWITCH_ON,
	input wire logic                    OPEN_LOAD_CHECK_EN
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	logic [`HBSC_SC_CNT_W-1:0] run_q;
	// Counts raw pin cycles, so the bound allows for the synchroniser lag.
	always_ff @(posedge CLK or negedge RSTN)
		if (!RSTN) run_q <= '0;
		else if (SHORT_CIRCUIT[0] && SWITCH_ON[0]) run_q <= run_q + 1'b1;
		else run_q <= '0;
	property p_oe_idle; CS_N [*6] |-> !SERIAL_OUT_OE && !SERIAL_OUT; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("serial out driven while deselected");
	property p_oe_on; !CS_N [*6] |-> SERIAL_OUT_OE; endproperty
	a_oe_on: assert property (p_oe_on) else $error("serial out not enabled in frame");
	property p_out_hold; (!SERIAL_CLK && !CS_N) [*7] |-> $stable(SERIAL_OUT); endproperty
	a_out_hold: assert property (p_out_hold) else $error("serial out moved without clock rise");
	property p_ctrl_hold;
		(!CS_N && STANDBY_PIN_N && !OVERTEMP && !LOAD_SUPPLY_LOW && SHORT_CIRCUIT == '0) [*8] |-> $stable(SWITCH_ON);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold) else $error("switches changed inside a frame");
	property p_stby; !STANDBY_PIN_N [*5] |-> SWITCH_ON == '0; endproperty
	a_stby: assert property (p_stby) else $error("stage on during pin standby");
	property p_ot; OVERTEMP [*5] |-> SWITCH_ON == '0; endproperty
	a_ot: assert property (p_ot) else $error("stage on during overtemperature");
	property p_olen; $changed(OPEN_LOAD_CHECK_EN) |-> $past(CS_N, 1) && $past(CS_N, 2); endproperty
	a_olen: assert property (p_olen) else $error("open-load enable moved inside frame");
	property p_trip; run_q <= SC_LONG_CYC + 4; endproperty
	a_trip: assert property (p_trip) else $error("shorted switch not tripped in time");
endmodule
bind hbsc_top hbsc_top_asserts #(.SC_LONG_CYC(SC_LONG_CYC), .SC_SHORT_CYC(SC_SHORT_CYC)) u_chk (
	.CLK(CLK), .RSTN(RSTN), .CS_N(CS_N), .SERIAL_CLK(SERIAL_CLK), .SERIAL_OUT(SERIAL_OUT),
	.SERIAL_OUT_OE(SERIAL_OUT_OE), .STANDBY_PIN_N(STANDBY_PIN_N), .OVERTEMP(OVERTEMP),
	.LOAD_SUPPLY_LOW(LOAD_SUPPLY_LOW), .SHORT_CIRCUIT(SHORT_CIRCUIT), .SWITCH_ON(SWITCH_ON),
	.OPEN_LOAD_CHECK_EN(OPEN_LOAD_CHECK_EN));
`default_nettype wire

// >>> dv/half_bridge_serial_control_test.sv
`timescale 1ns/1ns
`default_nettype none
module half_bridge_serial_control_test;
	logic        clk, rstn, pin_n, tp, ot, uv;
	logic [11:0] sc, ol;
	logic [15:0] rx;
	wire  logic  cs_n, sclk, sdi, so, so_oe, ol_en;
	wire  logic [11:0] sw;
	wire         sdo_line = so_oe ? so : 1'bz;
	int          err_total, samples_checked, cyc;
	hbsc_top #(.SC_LONG_CYC(18'h00028), .SC_SHORT_CYC(18'h0000a)) u_dut (
		.CLK(clk), .RSTN(rstn), .CS_N(cs_n), .SERIAL_CLK(sclk), .SERIAL_INPUT(sdi),
		.SERIAL_OUT(so), .SERIAL_OUT_OE(so_oe), .STANDBY_PIN_N(pin_n), .THERMAL_PREWARN(tp),
		.OVERTEMP(ot), .LOAD_SUPPLY_LOW(uv), .SHORT_CIRCUIT(sc), .OPEN_LOAD(ol),
		.SWITCH_ON(sw), .OPEN_LOAD_CHECK_EN(ol_en));
	hbsc_host u_host (.clk(clk), .sdo(sdo_line), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic conclude();
		if (err_total == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic f(input logic [15:0] tx);
		u_host.xfer(tx, 16, rx);
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end
	initial begin
		rstn = 1'b0;
		pin_n = 1'b1;
		tp = 1'b1;
		ot = 1'b0;
		uv = 1'b0;
		sc = 12'h000;
		ol = 12'h000;
		w(2);
		rstn <= 1'b1;
		w(4);
		f(16'h8000);
		chk(rx, 16'h0001);
		chk({15'h0000, ol_en}, 16'h0001);
		ol <= 12'h005;
		f(16'ha000);
		chk(rx, 16'h000b);
		chk({15'h0000, ol_en}, 16'h0000);
		// Each frame reads back the switch applied by the frame before it.
		for (int i = 0; i < 12; i++) begin
			f(16'ha000 | (16'h0002 << i));
			chk({4'h0, sw}, 16'h0001 << i);
			chk(rx, 16'h0001 | (16'h0001 << i));
		end
		u_host.xfer(16'h0000, 1, rx);
		chk({15'h0000, rx[0]}, 16'h0001);
		// With the prewarning gone the flag must read low, and the aborted frame must leave the switches unchanged.
		tp <= 1'b0;
		w(4);
		u_host.xfer(16'hffff, 1, rx);
		chk({15'h0000, rx[0]}, 16'h0000);
		tp <= 1'b1;
		chk({4'h0, sw}, 16'h0800);
		f(16'h2006);
		chk({4'h0, sw}, 16'h0000);
		f(16'ha006);
		chk(rx, 16'h4001);
		pin_n <= 1'b0;
		w(6);
		chk({4'h0, sw}, 16'h0000);
		f(16'ha006);
		chk(rx, 16'h4001);
		pin_n <= 1'b1;
		w(6);
		chk({4'h0, sw}, 16'h0003);
		sc <= 12'h001;
		w(8);
		chk({4'h0, sw}, 16'h0003);
		w(10);
		chk({4'h0, sw}, 16'h0002);
		sc <= 12'h000;
		f(16'ha006);
		chk(rx, 16'h2005);
		f(16'ha007);
		chk({4'h0, sw}, 16'h0003);
		f(16'he006);
		chk(rx, 16'h0007);
		sc <= 12'h001;
		w(30);
		chk({4'h0, sw}, 16'h0003);
		w(20);
		chk({4'h0, sw}, 16'h0002);
		sc <= 12'h000;
		uv <= 1'b1;
		w(6);
		uv <= 1'b0;
		w(4);
		f(16'ha006);
		chk(rx, 16'ha005);
		f(16'ha006);
		chk(rx, 16'ha005);
		f(16'ha007);
		f(16'ha006);
		chk(rx, 16'h0007);
		ot <= 1'b1;
		w(6);
		ot <= 1'b0;
		f(16'ha006);
		chk(rx, 16'hffff);
		f(16'ha007);
		chk(rx, 16'hffff);
		f(16'ha006);
		chk(rx, 16'h0007);
		conclude();
	end
endmodule
`default_nettype wire
